// ==== hdl/tqs_pkg.sv ====
// Constants shared by the torque input mode scaler
package tqs_pkg;
    // Register indices
    localparam logic [7:0] IDX_INPUT_SOURCE   = 8'h0C;
    localparam logic [7:0] IDX_INPUT_OFFSET   = 8'h0D;
    localparam logic [7:0] IDX_INPUT_DEADBAND = 8'h0E;
    localparam logic [7:0] IDX_MAX_INPUT      = 8'h0F;
    localparam logic [7:0] IDX_MAX_OUT_SCALE  = 8'h10;
    localparam logic [7:0] IDX_OUTPUT_OFFSET  = 8'h11;
    localparam logic [7:0] IDX_RATE_OF_CHANGE = 8'h12;
    localparam logic [7:0] IDX_CL_TORQUE_LIM  = 8'hCE;
    localparam logic [7:0] IDX_OL_TORQUE_LIM  = 8'hCF;
    // Field layout of the torque limit registers
    localparam int         LIM_RUN_LSB        = 0;
    localparam int         LIM_HOLD_LSB       = 16;
    localparam int         LIM_W              = 16;
    // Reset values and the input offset ceiling
    localparam logic [31:0] ZERO32            = 32'h0000_0000;
    localparam logic [31:0] MAX_INPUT_RST     = 32'h0000_7FFF;
    localparam logic [31:0] OFFSET_MAX        = 32'h0000_7FFF;
    localparam logic [31:0] LIMIT_RST         = 32'h4E20_4E20;
    // Timing
    localparam int         CLK_HZ             = 40_000_000;
    localparam int         SERVO_CYCLE_NS     = 120_000;
    localparam int         SERVO_CYCLES       = SERVO_CYCLE_NS / (1_000_000_000 / CLK_HZ);
    // Speed guard
    localparam logic [15:0] MAX_SPEED_RPM     = 16'h0FA0;
    // Slew factor in hundredths
    localparam logic [6:0] SLEW_MIN           = 7'h02;
    localparam logic [6:0] SLEW_MAX           = 7'h64;
    localparam logic [6:0] SLEW_DEFAULT       = 7'h0A;
    localparam logic [15:0] SLEW_UNIT         = 16'h0064;
    // Divider
    localparam int         DIV_W              = 64;
    localparam logic [6:0] DIV_STEPS          = 7'h40;
endpackage : tqs_pkg

// ==== hdl/tqs_div.sv ====
// Sequential unsigned restoring divider used for normalisation
`timescale 1ns/1ps
`default_nettype none
module tqs_div
    import tqs_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Request
    input  wire logic             start_i,
    input  wire logic [DIV_W-1:0] num_i,
    input  wire logic [31:0]      den_i,
    // Answer
    output logic                  done_o,
    output logic      [DIV_W-1:0] quot_o
);
    logic [DIV_W-1:0] quot_reg;
    logic [DIV_W:0]   rem_reg;
    logic [31:0]      den_reg;
    logic [6:0]       cnt_reg;
    logic             busy_reg;
    logic             done_reg;
    logic [DIV_W:0]   trial;

    assign trial  = {rem_reg[DIV_W-1:0], quot_reg[DIV_W-1]};
    assign done_o = done_reg;
    assign quot_o = quot_reg;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            quot_reg <= '0;
            rem_reg  <= '0;
            den_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (start_i && !busy_reg)
            begin
                quot_reg <= num_i;
                rem_reg  <= '0;
                den_reg  <= den_i;
                cnt_reg  <= DIV_STEPS;
                busy_reg <= 1'b1;
            end
            else if (busy_reg)
            begin
                // One quotient bit per clock
                if (trial >= {33'h0, den_reg})
                begin
                    rem_reg  <= trial - {33'h0, den_reg};
                    quot_reg <= {quot_reg[DIV_W-2:0], 1'b1};
                end
                else
                begin
                    rem_reg  <= trial;
                    quot_reg <= {quot_reg[DIV_W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 7'h01;
                if (cnt_reg == 7'h01)
                begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end
endmodule // tqs_div
`default_nettype wire

// ==== hdl/tqs_top.sv ====
// Torque input mode scaler: registers, servo tick and torque command
// Operation
// - Each torque update is clamped to the closed loop running torque limit sampled at its servo tick while the mode is active.
// - The output rate-of-change register is stored but has no effect on the torque output.
// - With continuous analog reading on, the input source register is loaded from the analog channel every servo cycle.
// - The input offset, limited to 0..32767, is subtracted from the input source value.
// - A torque is computed only when the absolute input minus offset is at least the deadband.
// - Input minus deadband minus offset is clamped to plus/minus (max input - deadband) and divided by it.
// - The normalised input is multiplied by the maximum output scale.
// - The output offset is added last to form the torque command.
// - Torque that would push the shaft past the maximum speed is removed automatically.
// - A low-pass input filter with truncating arithmetic smooths the input at the chosen cutoff.
// - Torque change per servo cycle is limited by a slew factor between 0.02 and 1.0.
// - The mode ends when the exit condition on digital input five low is selected and met.
// - A new torque limit is sampled at the next servo tick and applied 66 clocks after it.
// - The closed loop limit register holds the holding limit high and the running limit low.
`timescale 1ns/1ps
`default_nettype none
module tqs_top
    import tqs_pkg::*;
#(
    parameter int SERVO_PERIOD = SERVO_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_idx_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    output logic             reg_ack_o,
    // Mode control
    input  wire logic        mode_enter_i,
    input  wire logic        mode_leave_i,
    input  wire logic        exit_on_in5_low_i,
    input  wire logic        dig_in5_i,
    input  wire logic        analog_continuous_read_i,
    input  wire logic [15:0] analog_sample_i,
    input  wire logic [3:0]  filter_shift_i,
    input  wire logic [6:0]  slew_factor_i,
    input  wire logic [15:0] shaft_speed_i,
    // Status and command
    output logic             torque_input_mode_o,
    output logic             servo_tick_o,
    output logic      [31:0] torque_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_APPLY} tqs_state_type;

    // Saturate a wide signed value to 32 bits
    function automatic logic [31:0] sat32(input logic signed [65:0] v);
        if (v > 66'sh0_0000_0000_7FFF_FFFF)
            sat32 = 32'h7FFF_FFFF;
        else if (v < -66'sh0_0000_0000_8000_0000)
            sat32 = 32'h8000_0000;
        else
            sat32 = v[31:0];
    endfunction

    // Clamp a signed value to plus/minus a non-negative bound
    function automatic logic signed [65:0] clampsym(input logic signed [65:0] v,
                                                    input logic signed [65:0] b);
        if (v > b)
            clampsym = b;
        else if (v < -b)
            clampsym = -b;
        else
            clampsym = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] src_reg, off_reg, db_reg, maxin_reg, oscale_reg, ooff_reg, roc_reg;
    logic [31:0] cl_lim_reg, ol_lim_reg, run_lim_reg;
    logic [31:0] filt_reg;
    logic        mode_reg;
    logic [31:0] cnt_reg;
    logic        tick;
    logic        exit_now;

    assign tick         = (cnt_reg == 32'(SERVO_PERIOD - 1));
    assign servo_tick_o = tick;
    assign exit_now     = exit_on_in5_low_i && !dig_in5_i;
    assign torque_input_mode_o = mode_reg;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_reg <= '0;
        else if (tick)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + 32'h1;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            mode_reg <= 1'b0;
        else if (mode_leave_i || exit_now)
            mode_reg <= 1'b0;
        else if (mode_enter_i)
            mode_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; analog refresh beats a host write on the tick
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            src_reg    <= ZERO32;
            off_reg    <= ZERO32;
            db_reg     <= ZERO32;
            maxin_reg  <= MAX_INPUT_RST;
            oscale_reg <= ZERO32;
            ooff_reg   <= ZERO32;
            roc_reg    <= ZERO32;
            cl_lim_reg <= LIMIT_RST;
            ol_lim_reg <= LIMIT_RST;
        end
        else
        begin
            if (reg_wr_i)
            begin
                unique case (reg_idx_i)
                    IDX_INPUT_SOURCE:   src_reg    <= reg_wdata_i;
                    IDX_INPUT_OFFSET:   off_reg    <= (reg_wdata_i > OFFSET_MAX) ? OFFSET_MAX
                                                                                 : reg_wdata_i;
                    IDX_INPUT_DEADBAND: db_reg     <= reg_wdata_i;
                    IDX_MAX_INPUT:      maxin_reg  <= reg_wdata_i;
                    IDX_MAX_OUT_SCALE:  oscale_reg <= reg_wdata_i;
                    IDX_OUTPUT_OFFSET:  ooff_reg   <= reg_wdata_i;
                    IDX_RATE_OF_CHANGE: roc_reg    <= reg_wdata_i;
                    IDX_CL_TORQUE_LIM:  cl_lim_reg <= reg_wdata_i;
                    IDX_OL_TORQUE_LIM:  ol_lim_reg <= reg_wdata_i;
                    default: ;
                endcase
            end
            if (tick && analog_continuous_read_i)
                src_reg <= {{16{analog_sample_i[15]}}, analog_sample_i};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= ZERO32;
        else if (reg_rd_i)
        begin
            unique case (reg_idx_i)
                IDX_INPUT_SOURCE:   reg_rdata_o <= src_reg;
                IDX_INPUT_OFFSET:   reg_rdata_o <= off_reg;
                IDX_INPUT_DEADBAND: reg_rdata_o <= db_reg;
                IDX_MAX_INPUT:      reg_rdata_o <= maxin_reg;
                IDX_MAX_OUT_SCALE:  reg_rdata_o <= oscale_reg;
                IDX_OUTPUT_OFFSET:  reg_rdata_o <= ooff_reg;
                IDX_RATE_OF_CHANGE: reg_rdata_o <= roc_reg;
                IDX_CL_TORQUE_LIM:  reg_rdata_o <= cl_lim_reg;
                IDX_OL_TORQUE_LIM:  reg_rdata_o <= ol_lim_reg;
                default:            reg_rdata_o <= ZERO32;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_ack_o <= 1'b0;
        else
            reg_ack_o <= reg_wr_i || reg_rd_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input filter; the truncating shift is what costs resolution at low cutoff
    logic signed [32:0] filt_diff;
    assign filt_diff = $signed({src_reg[31], src_reg}) - $signed({filt_reg[31], filt_reg});

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            filt_reg <= ZERO32;
        else if (tick)
            filt_reg <= sat32(66'($signed(filt_reg)) + 66'(filt_diff >>> filter_shift_i));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Normalisation stage
    logic signed [65:0] in_s, off_s, db_s, span_s, diff_s, x_s, prod_s;
    logic               in_band;
    logic               span_ok;
    logic [DIV_W-1:0]   div_num;
    logic [DIV_W-1:0]   div_quot;
    logic               div_done;
    logic               div_start;
    logic               neg_reg;
    logic               band_reg;
    tqs_state_type      state_reg;

    always_comb
    begin
        in_s    = 66'($signed(filt_reg));
        off_s   = 66'($signed(off_reg));
        db_s    = 66'($signed(db_reg));
        span_s  = 66'($signed(maxin_reg)) - db_s;
        diff_s  = in_s - off_s;
        in_band = ((diff_s < 0) ? -diff_s : diff_s) >= db_s;
        span_ok = span_s > 0;
        x_s     = clampsym(in_s - db_s - off_s, span_s);
        prod_s  = x_s * 66'($signed(oscale_reg));
        div_num = (prod_s < 0) ? 64'(-prod_s) : 64'(prod_s);
    end

    assign div_start = (state_reg == ST_IDLE) && tick && mode_reg;

    tqs_div u_div (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .start_i  (div_start),
        .num_i    (div_num),
        .den_i    (span_ok ? span_s[31:0] : 32'h0000_0001),
        .done_o   (div_done),
        .quot_o   (div_quot)
    );

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg   <= ST_IDLE;
            neg_reg     <= 1'b0;
            band_reg    <= 1'b0;
            run_lim_reg <= ZERO32;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (div_start)
                    begin
                        neg_reg     <= prod_s < 0;
                        band_reg    <= in_band && span_ok;
                        run_lim_reg <= {16'h0000, cl_lim_reg[LIM_RUN_LSB +: LIM_W]};
                        state_reg   <= ST_DIV;
                    end
                ST_DIV:
                    if (div_done)
                        state_reg <= ST_APPLY;
                ST_APPLY:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset, limits, speed guard and slew
    logic signed [65:0] scaled_s, cmd_s, lim_s, tgt_s, cur_s, step_s, delta_s;
    logic [6:0]         kf;

    always_comb
    begin
        kf       = (slew_factor_i < SLEW_MIN) ? SLEW_MIN :
                   (slew_factor_i > SLEW_MAX) ? SLEW_MAX : slew_factor_i;
        scaled_s = band_reg ? (neg_reg ? -66'(div_quot) : 66'(div_quot)) : 66'sh0;
        cmd_s    = 66'($signed(sat32(scaled_s))) + 66'($signed(ooff_reg));
        lim_s    = 66'(run_lim_reg);
        tgt_s    = clampsym(cmd_s, lim_s);
        // Drop torque that would accelerate past the speed ceiling
        if ($signed(shaft_speed_i) >= $signed(MAX_SPEED_RPM) && tgt_s > 0)
            tgt_s = 66'sh0;
        if ($signed(shaft_speed_i) <= -$signed(MAX_SPEED_RPM) && tgt_s < 0)
            tgt_s = 66'sh0;
        cur_s    = 66'($signed(torque_o));
        step_s   = 66'(kf) * 66'(SLEW_UNIT);
        delta_s  = clampsym(tgt_s - cur_s, step_s);
    end

    // Rate-of-change register deliberately not consulted here
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            torque_o <= ZERO32;
        else if (!mode_reg)
            torque_o <= ZERO32;
        else if (state_reg == ST_APPLY)
            torque_o <= sat32(clampsym(cur_s + delta_s, lim_s));
    end
endmodule // tqs_top
`default_nettype wire

// ==== dv/tqs_analog_model.sv ====
// Analog channel model feeding the input source sample
`timescale 1ns/1ps
`default_nettype none
module tqs_analog_model
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Conversion trigger and level
    input  wire logic        tick_i,
    input  wire logic [15:0] level_i,
    // Converted sample
    output logic      [15:0] sample_o
);
    // New code only once per servo cycle, so the level shows up one cycle late
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i) sample_o <= 16'h0000;
        else if (tick_i) sample_o <= level_i;
endmodule // tqs_analog_model
`default_nettype wire

// ==== dv/tqs_monitor.sv ====
// Port-level assertions for the torque input mode scaler
`timescale 1ns/1ps
`default_nettype none
module tqs_monitor
    import tqs_pkg::*;
#(
    parameter int SERVO_PERIOD = SERVO_CYCLES
)
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // Register port
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_idx_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_ack_o,
    // Mode control
    input wire logic        mode_enter_i,
    input wire logic        mode_leave_i,
    input wire logic        exit_on_in5_low_i,
    input wire logic        dig_in5_i,
    input wire logic        analog_continuous_read_i,
    input wire logic [15:0] analog_sample_i,
    input wire logic [3:0]  filter_shift_i,
    input wire logic [6:0]  slew_factor_i,
    input wire logic [15:0] shaft_speed_i,
    // Status and command
    input wire logic        torque_input_mode_o,
    input wire logic        servo_tick_o,
    input wire logic [31:0] torque_o
);
    int unsigned        cnt;
    logic [15:0]        lim_reg;
    logic [15:0]        lim_tick;
    logic               spd_tick, mode_prev, upd;
    logic [31:0]        prev_t;
    logic [6:0]         kf;
    logic signed [32:0] dlt;
    logic signed [32:0] step;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i) cnt <= 0;
        else cnt <= servo_tick_o ? 0 : cnt + 1;
    // Limit as the pipeline samples it at the tick, and speed at the same tick
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i) lim_reg <= LIMIT_RST[15:0];
        else if (reg_wr_i && reg_idx_i == IDX_CL_TORQUE_LIM) lim_reg <= reg_wdata_i[15:0];
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            lim_tick <= LIMIT_RST[15:0];
            spd_tick <= 1'b0;
        end
        else if (servo_tick_o)
        begin
            lim_tick <= lim_reg;
            spd_tick <= $signed(shaft_speed_i) >= $signed(MAX_SPEED_RPM);
        end
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            prev_t    <= ZERO32;
            mode_prev <= 1'b0;
        end
        else
        begin
            prev_t    <= torque_o;
            mode_prev <= torque_input_mode_o;
        end
    assign upd  = torque_input_mode_o && mode_prev && (torque_o != prev_t);
    assign dlt  = $signed({torque_o[31], torque_o}) - $signed({prev_t[31], prev_t});
    assign kf   = (slew_factor_i < SLEW_MIN) ? SLEW_MIN : (slew_factor_i > SLEW_MAX) ? SLEW_MAX : slew_factor_i;
    assign step = 33'(int'(kf) * int'(SLEW_UNIT));
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_exit_req;
        torque_input_mode_o && (mode_leave_i || (exit_on_in5_low_i && !dig_in5_i));
    endsequence
    sequence s_off_two;
        !torque_input_mode_o [*2];
    endsequence
    AST_ACK: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("register strobe not acknowledged");
    AST_EXIT: assert property (s_exit_req |=> !torque_input_mode_o)
        else $error("mode did not end on exit condition");
    AST_ENTER: assert property ((mode_enter_i && !mode_leave_i && !(exit_on_in5_low_i && !dig_in5_i))
        |=> torque_input_mode_o)
        else $error("mode not entered");
    AST_ZERO_OFF: assert property (s_off_two |-> torque_o == ZERO32)
        else $error("torque not zero outside the mode");
    AST_TICK: assert property (servo_tick_o |-> cnt == SERVO_PERIOD - 1)
        else $error("servo tick off period");
    AST_TICK_DUE: assert property (cnt == SERVO_PERIOD - 1 |-> servo_tick_o)
        else $error("servo tick missing");
    AST_LIMIT: assert property (upd |-> $signed(torque_o) <= $signed({16'h0000, lim_tick})
        && $signed(torque_o) >= -$signed({16'h0000, lim_tick}))
        else $error("torque beyond running limit");
    AST_SLEW: assert property (upd |-> ((dlt < 0) ? -dlt : dlt) <= step)
        else $error("torque step above slew bound");
    AST_SPEED: assert property ((upd && spd_tick && $signed(shaft_speed_i) >= $signed(MAX_SPEED_RPM))
        |-> ($signed(torque_o) <= 0 || $signed(torque_o) <= $signed(prev_t)))
        else $error("torque raised at maximum speed");
    AST_LATENCY: assert property (upd |-> (cnt >= 65 && cnt <= 67))
        else $error("torque update at wrong time");
endmodule // tqs_monitor
bind tqs_top tqs_monitor #(.SERVO_PERIOD(SERVO_PERIOD)) u_monitor (
    .clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
    .mode_enter_i, .mode_leave_i, .exit_on_in5_low_i, .dig_in5_i, .analog_continuous_read_i,
    .analog_sample_i, .filter_shift_i, .slew_factor_i, .shaft_speed_i,
    .torque_input_mode_o, .servo_tick_o, .torque_o
);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking testbench for the torque input mode scaler
`timescale 1ns/1ps
`default_nettype none
module tb
    import tqs_pkg::*;
();
    localparam int SP = 100;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_idx_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic        mode_enter_i = 1'b0;
    logic        mode_leave_i = 1'b0;
    logic        exit_on_in5_low_i = 1'b0;
    logic        dig_in5_i = 1'b1;
    logic        analog_continuous_read_i = 1'b0;
    logic [15:0] level = 16'h0000;
    logic [6:0]  slew_factor_i = SLEW_MAX;
    logic [15:0] shaft_speed_i = 16'h0000;
    logic [3:0]  filter_shift_i = 4'h0;
    wire  logic [15:0] analog_sample_i;
    wire  logic [31:0] reg_rdata_o;
    wire  logic [31:0] torque_o;
    wire  logic        reg_ack_o;
    wire  logic        torque_input_mode_o;
    wire  logic        servo_tick_o;
    int          num_errors = 0;
    int          comparisons = 0;
    longint      off = 1000, db = 500, mx = 32767, sc = 3000, oo = 20, lim = 20000;
    // Fast servo period keeps the run short; pipeline needs at least 67
    tqs_top #(.SERVO_PERIOD(SP)) DUT (
        .clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
        .mode_enter_i, .mode_leave_i, .exit_on_in5_low_i, .dig_in5_i, .analog_continuous_read_i,
        .analog_sample_i, .filter_shift_i, .slew_factor_i, .shaft_speed_i,
        .torque_input_mode_o, .servo_tick_o, .torque_o
    );
    tqs_analog_model u_adc (.clk_i, .resetn_i, .tick_i(servo_tick_o), .level_i(level), .sample_o(analog_sample_i));
    always #12.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        reg_idx_i = idx;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(posedge clk_i);
        #2;
        reg_wr_i = 1'b0;
        @(posedge clk_i);
        #2;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
        reg_idx_i = idx;
        reg_rd_i = 1'b1;
        @(posedge clk_i);
        #2;
        reg_rd_i = 1'b0;
        chk("reg_rdata_o", e, reg_rdata_o);
        @(posedge clk_i);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clk_i);
        #2;
        s = 1'b0;
        @(posedge clk_i);
        #2;
    endtask
    // Waits for n ticks, then for the 66-cycle pipeline to land
    task automatic wait_ticks(input int n);
        int seen;
        seen = 0;
        for (int k = 0; k < (n + 1) * SP && seen < n; k++)
        begin
            @(negedge clk_i);
            if (servo_tick_o === 1'b1) seen++;
        end
        if (seen < n)
        begin
            num_errors++;
            summarize();
        end
        repeat (70) @(posedge clk_i);
        #2;
    endtask
    function automatic logic [31:0] expt(input longint src);
        longint d;
        longint x;
        longint den;
        longint s;
        d   = src - off;
        den = mx - db;
        s   = 0;
        if ((d < 0 ? -d : d) >= db && den > 0)
        begin
            x = src - db - off;
            x = (x > den) ? den : (x < -den) ? -den : x;
            s = (x * sc) / den;
        end
        s = s + oo;
        s = (s > lim) ? lim : (s < -lim) ? -lim : s;
        return 32'(s);
    endfunction
    ////////////////////////////////////////////////////////////
    task automatic t_reset_regs();
        for (int i = 12; i <= 18; i++)
            rd_chk(i[7:0], (i == 15) ? MAX_INPUT_RST : ZERO32);
        rd_chk(IDX_CL_TORQUE_LIM, LIMIT_RST);
        rd_chk(IDX_OL_TORQUE_LIM, LIMIT_RST);
    endtask
    task automatic t_regs_rw();
        logic [31:0] v;
        for (int i = 12; i <= 18; i++)
        begin
            v = 32'h1234_5600 | 32'(i);
            wr(i[7:0], v);
            rd_chk(i[7:0], (i == 13) ? OFFSET_MAX : v);
        end
        wr(IDX_CL_TORQUE_LIM, 32'h0FA0_4E21);
        rd_chk(IDX_CL_TORQUE_LIM, 32'h0FA0_4E21);
        wr(IDX_OL_TORQUE_LIM, 32'h0FA0_4E20);
        rd_chk(IDX_OL_TORQUE_LIM, 32'h0FA0_4E20);
        wr(8'h20, 32'hFFFF_FFFF);
        rd_chk(8'h20, ZERO32);
    endtask
    task automatic t_torque();
        longint v[5] = '{16883, -16883, 1499, 2000, 40000};
        wr(IDX_CL_TORQUE_LIM, LIMIT_RST);
        wr(IDX_INPUT_OFFSET, 32'h0000_03E8);
        wr(IDX_INPUT_DEADBAND, 32'h0000_01F4);
        wr(IDX_MAX_INPUT, MAX_INPUT_RST);
        wr(IDX_MAX_OUT_SCALE, 32'h0000_0BB8);
        wr(IDX_OUTPUT_OFFSET, 32'h0000_0014);
        wr(IDX_RATE_OF_CHANGE, ZERO32);
        wr(IDX_INPUT_SOURCE, 32'(v[0]));
        pulse(mode_enter_i);
        foreach (v[i])
        begin
            wr(IDX_INPUT_SOURCE, 32'(v[i]));
            wait_ticks(3);
            chk("torque_o", expt(v[i]), torque_o);
        end
    endtask
    task automatic t_limit();
        lim = 512;
        wr(IDX_CL_TORQUE_LIM, 32'h4E20_0200);
        wait_ticks(2);
        chk("torque_o", expt(40000), torque_o);
        lim = 20000;
        wr(IDX_CL_TORQUE_LIM, LIMIT_RST);
    endtask
    task automatic t_saturate();
        sc = 64'h7FFF_FFFF;
        oo = 64'h7FFF_FFFF;
        wr(IDX_MAX_OUT_SCALE, 32'h7FFF_FFFF);
        wr(IDX_OUTPUT_OFFSET, 32'h7FFF_FFFF);
        wait_ticks(3);
        chk("torque_o", expt(40000), torque_o);
        sc = 3000;
        oo = 20;
        wr(IDX_MAX_OUT_SCALE, 32'h0000_0BB8);
        wr(IDX_OUTPUT_OFFSET, 32'h0000_0014);
        wait_ticks(3);
        chk("torque_o", expt(40000), torque_o);
    endtask
    task automatic t_speed();
        shaft_speed_i = MAX_SPEED_RPM;
        wait_ticks(2);
        chk("torque_o", ZERO32, torque_o);
        shaft_speed_i = 16'hF060;
        wait_ticks(2);
        chk("torque_o", expt(40000), torque_o);
        shaft_speed_i = 16'h0000;
    endtask
    task automatic t_slew();
        pulse(mode_leave_i);
        chk("torque_o", ZERO32, torque_o);
        slew_factor_i = 7'h01;
        wait_ticks(1);
        pulse(mode_enter_i);
        wait_ticks(1);
        chk("torque_o", 32'h0000_00C8, torque_o);
        wait_ticks(1);
        chk("torque_o", 32'h0000_0190, torque_o);
        slew_factor_i = SLEW_MAX;
    endtask
    task automatic t_analog();
        level = 16'h1234;
        analog_continuous_read_i = 1'b1;
        wait_ticks(2);
        rd_chk(IDX_INPUT_SOURCE, 32'h0000_1234);
        wait_ticks(2);
        chk("torque_o", expt(4660), torque_o);
        filter_shift_i = 4'h1;
        level = 16'h2234;
        wait_ticks(4);
        chk("torque_o", expt(6708), torque_o);
    endtask
    task automatic t_exit();
        chk("torque_input_mode_o", 32'h1, 32'(torque_input_mode_o));
        exit_on_in5_low_i = 1'b1;
        dig_in5_i = 1'b0;
        @(posedge clk_i);
        #2;
        chk("torque_input_mode_o", 32'h0, 32'(torque_input_mode_o));
        repeat (2) @(posedge clk_i);
        #2;
        chk("torque_o", ZERO32, torque_o);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk_i);
        #2;
        resetn_i = 1'b1;
        t_reset_regs();
        t_regs_rw();
        t_torque();
        t_limit();
        t_saturate();
        t_speed();
        t_slew();
        t_analog();
        t_exit();
        summarize();
    end
endmodule // tb
`default_nettype wire
